// ==== array_pkg.sv ====
// Purpose: Shared constants and types for the linear array readout ends
// Assumes: One system clock; readout clock derived by division
// Notes:   Pixel values are digital stand-ins for the analog levels
`default_nettype none
package array_pkg;
  localparam int unsigned PIXEL_COUNT      = 896;
  localparam int unsigned PIX_W            = 8;
  localparam int unsigned IDX_W            = 10;
  localparam int unsigned CLK_HZ           = 50_000_000;
  localparam int unsigned MAX_READ_HZ      = 5_000_000;
  // Least half period of the readout clock, rounded up to whole cycles
  localparam int unsigned HALF_DIV         = (CLK_HZ + 2 * MAX_READ_HZ - 1) / (2 * MAX_READ_HZ);
  localparam int unsigned MAX_INT_MS       = 100;
  localparam int unsigned MAX_INT_CYC      = CLK_HZ / 1000 * MAX_INT_MS;
  localparam int unsigned FLUSH_CLOCKS     = PIXEL_COUNT + 1;
  localparam int unsigned FIFO_DEPTH       = 8;
  localparam logic [IDX_W-1:0] IDX_RST     = 10'h000;
  localparam logic [PIX_W-1:0] PIX_RST     = 8'h00;

  typedef enum logic [1:0] {
    C_IDLE  = 2'b00,
    C_START = 2'b01,
    C_RUN   = 2'b10,
    C_GAP   = 2'b11
  } ctl_state_e;
endpackage : array_pkg
`default_nettype wire

// ==== array_link_if.sv ====
// Purpose: Pin bundle between the array and its controller
// Assumes: Output float is shown by the output enable
// Notes:   Level of the analog pin is resolved by the bench
`default_nettype none
interface array_link_if;
  import array_pkg::*;
  logic             read_clk;
  logic             start_pulse;
  logic [PIX_W-1:0] pixel_out;
  logic             pixel_oe;
  logic             end_of_sequence_out;
  modport array_end (input read_clk, input start_pulse,
                     output pixel_out, output pixel_oe, output end_of_sequence_out);
  modport ctl_end (output read_clk, output start_pulse,
                   input pixel_out, input pixel_oe, input end_of_sequence_out);
endinterface : array_link_if
`default_nettype wire

// ==== sample_fifo.sv ====
// Purpose: Parameterised valid/ready FIFO for captured pixels
// Assumes: Single clock
// Notes:   Full stalls the writer; drain side may stall
`default_nettype none
module sample_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  input  wire logic             IN_VALID,
  output logic                  IN_READY,
  input  wire logic [WIDTH-1:0] IN_DATA,
  output logic                  OUT_VALID,
  input  wire logic             OUT_READY,
  output logic      [WIDTH-1:0] OUT_DATA
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q, rd_q;
  logic [AW:0]      cnt_q;
  logic             push, pop;
  assign IN_READY  = (cnt_q != (AW+1)'(DEPTH));
  assign OUT_VALID = (cnt_q != '0);
  assign OUT_DATA  = mem_q[rd_q];
  assign push      = IN_VALID && IN_READY;
  assign pop       = OUT_VALID && OUT_READY;
  always_ff @(posedge CLK) begin
    if (push) begin
      mem_q[wr_q] <= IN_DATA;
    end
  end
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : sample_fifo
`default_nettype wire

// ==== array_end.sv ====
// Contract
// R1 - Start pulse selects pixel one
// R2 - Accessed pixel: hold sample, clear integrator
// R3 - Next period: release reset, resume sampling
// R4 - Advance one pixel per clock period
// R5 - Integration equals interval between reads
// R6 - Controller expects time follows clock, spacing
// R7 - Output floats after clock edge n+1
// R8 - New start accepted on clock n+1
// R9 - Power-up: start then n+1 flush clocks
// R10 - Starts effective only after flush completes
// R11 - Controller holds clock low when idle
// R12 - Start recognised on low-to-high transition
// R13 - Integration at least 896 clock periods
// R14 - Integration not above 100 ms
// R15 - Readout clock no faster than 5 MHz
// R16 - Pixel held whole period; sample within
// R17 - Clock change mid-readout skews integration
// R18 - Shorten integration on saturation, above minimum; ctl_end does not, its gap stays fixed by GAP_CLKS
// R19 - Start low before next rising edge
// R20 - Advance on rising edge; idle otherwise
// R21 - End-of-sequence raised with last pixel
//
// Purpose: Behavioural digital model of the pixel array's sequencing logic
// Assumes: Readout clock and start are synchronous samples of CLK
// Notes:   Pixel value is a light input times integration length, saturated
`default_nettype none
module array_end
  import array_pkg::*;
#(
  parameter int unsigned PIXELS = PIXEL_COUNT
) (
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  array_link_if.array_end       LINK,
  input  wire logic [PIX_W-1:0] LIGHT_LEVEL,
  output logic      [IDX_W-1:0] ACCESS_INDEX,
  output logic                  INTEGRATOR_RESET_SWITCH,
  output logic                  SAMPLE_HOLD_SWITCH
);
  typedef struct packed {
    logic             clk_prev;
    logic             start_seen;
    logic             active;
    logic [IDX_W-1:0] idx;
    logic [PIX_W-1:0] out;
    logic             oe;
    logic             eos;
    logic             rst_sw;
    logic             hold_sw;
  } arr_s;
  arr_s st_q, st_d;
  // One integration accumulator per pixel; read then cleared on access
  logic [15:0] acc_q [PIXEL_COUNT];
  logic        rise;

  // A saturated pixel reads all ones; the controller must shorten integration
  function automatic logic [PIX_W-1:0] sat(input logic [15:0] v); // [R18]
    return (v[15:PIX_W] != '0) ? {PIX_W{1'b1}} : v[PIX_W-1:0];
  endfunction : sat

  assign rise = LINK.read_clk && !st_q.clk_prev;     // [R20]

  always_comb begin
    st_d          = st_q;
    st_d.clk_prev = LINK.read_clk;
    if (rise) begin
      st_d.rst_sw  = 1'b0;                           // [R3]
      st_d.hold_sw = 1'b0;                           // [R3]
      st_d.eos     = 1'b0;
      // Start high on a rising edge is a new frame, sampled once
      if (LINK.start_pulse && !st_q.start_seen) begin // [R12] [R8]
        st_d.active  = 1'b1;
        st_d.idx     = IDX_RST;                      // [R1]
        st_d.out     = sat(acc_q[0]);                // [R5]
        st_d.oe      = 1'b1;
        st_d.hold_sw = 1'b1;                         // [R2]
        st_d.rst_sw  = 1'b1;                         // [R2]
        st_d.eos     = (PIXELS == 1);
      end else if (st_q.active && st_q.idx != IDX_W'(PIXELS - 1)) begin
        st_d.idx     = st_q.idx + 1'b1;              // [R4]
        st_d.out     = sat(acc_q[st_q.idx + 1'b1]);  // [R16]
        st_d.hold_sw = 1'b1;                         // [R2]
        st_d.rst_sw  = 1'b1;                         // [R2]
        st_d.eos     = (st_q.idx == IDX_W'(PIXELS - 2)); // [R21]
      end else if (st_q.active) begin
        // Edge n+1 ends the frame and floats the output
        st_d.active = 1'b0;
        st_d.oe     = 1'b0;                          // [R7]
        st_d.out    = PIX_RST;
      end
      st_d.start_seen = LINK.start_pulse;
    end
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      st_q <= '{clk_prev: 1'b0, start_seen: 1'b0, active: 1'b0, idx: IDX_RST,
                out: PIX_RST, oe: 1'b0, eos: 1'b0, rst_sw: 1'b0, hold_sw: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  // Charge grows every readout edge; the accessed pixel restarts from zero
  always_ff @(posedge CLK) begin
    for (int i = 0; i < PIXEL_COUNT; i++) begin
      if (rise) begin
        if (st_d.rst_sw && st_d.idx == IDX_W'(i)) begin
          acc_q[i] <= '0;                            // [R2] [R5]
        end else if (acc_q[i] != 16'hFFFF) begin
          acc_q[i] <= acc_q[i] + 16'(LIGHT_LEVEL);
        end
      end
    end
  end

  assign LINK.pixel_out           = st_q.out;
  assign LINK.pixel_oe            = st_q.oe;
  assign LINK.end_of_sequence_out = st_q.eos;
  assign ACCESS_INDEX             = st_q.idx;
  assign INTEGRATOR_RESET_SWITCH  = st_q.rst_sw;
  assign SAMPLE_HOLD_SWITCH       = st_q.hold_sw;
endmodule : array_end
`default_nettype wire

// ==== ctl_end.sv ====
// Purpose: Controller that clocks the array, starts frames, buffers pixels
// Assumes: Readout clock from CLK by a divider
// Notes:   First frame after reset is a flush and is discarded
`default_nettype none
module ctl_end
  import array_pkg::*;
#(
  parameter int unsigned PIXELS    = PIXEL_COUNT,
  parameter int unsigned HALF      = HALF_DIV,
  parameter int unsigned GAP_CLKS  = 0,
  parameter int unsigned DEPTH     = FIFO_DEPTH
) (
  input  wire logic             CLK,
  input  wire logic             SYS_RST,
  array_link_if.ctl_end         LINK,
  input  wire logic             RUN,
  output logic                  PIX_VALID,
  input  wire logic             PIX_READY,
  output logic      [PIX_W-1:0] PIX_DATA,
  output logic                  FRAME_DONE,
  output logic                  FLUSHED
);
  typedef struct packed {
    ctl_state_e       state;
    logic [7:0]       div;
    logic             rclk;
    logic             si;
    logic [IDX_W:0]   edges;
    logic [15:0]      gap;
    logic             flushed;
    logic             done;
    logic             cap;
    logic [PIX_W-1:0] cap_data;
  } ctl_s;
  ctl_s c_q, c_d;
  logic fifo_in_ready;
  logic half_end;

  assign half_end = (c_q.div == 8'(HALF - 1));

  always_comb begin
    c_d      = c_q;
    c_d.done = 1'b0;
    c_d.cap  = 1'b0;
    if (c_q.state != C_IDLE) begin
      // Stall the clock while the buffer is full so no pixel is lost;
      // a stall stretches one period, so pixel integration times differ [R17]
      if (!(c_q.rclk == 1'b0 && half_end && !fifo_in_ready)) begin
        c_d.div = half_end ? 8'h00 : c_q.div + 8'h01;         // [R15]
      end
    end
    unique case (c_q.state)
      C_IDLE: begin
        c_d.rclk = 1'b0;                                      // [R11]
        c_d.div  = 8'h00;
        if (RUN || !c_q.flushed) begin                        // [R9]
          c_d.state = C_START;
          c_d.si    = 1'b1;
          c_d.edges = '0;
        end
      end
      C_START, C_RUN: begin
        if (half_end && (c_q.rclk || fifo_in_ready)) begin
          c_d.rclk = !c_q.rclk;
          if (c_q.rclk) begin
            c_d.si = 1'b0;                                    // [R19]
            if (c_q.state == C_START) begin
              c_d.state = C_RUN;
            end
          end else begin
            c_d.edges = c_q.edges + 1'b1;
            // Pixel from the previous edge is sampled before this edge
            c_d.cap      = c_q.flushed && LINK.pixel_oe;      // [R10] [R16]
            c_d.cap_data = LINK.pixel_out;
            if (c_q.edges == (IDX_W+1)'(PIXELS)) begin        // [R8]
              c_d.state   = C_GAP;
              c_d.gap     = 16'(GAP_CLKS);                    // [R6]
              c_d.done    = c_q.flushed;
              c_d.flushed = 1'b1;                             // [R10]
            end
          end
        end
      end
      C_GAP: begin
        // Spacing sets the integration time; no clock during the gap
        // The last high phase must finish its count before the clock parks low
        if (!c_q.rclk) begin
          c_d.div = 8'h00;
        end
        c_d.rclk = (c_q.rclk && !half_end);
        if (c_q.gap != 16'h0000) begin                        // [R13] [R14]
          c_d.gap = c_q.gap - 16'h0001;
        end else if (!c_q.rclk) begin
          c_d.state = C_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      c_q <= '{state: C_IDLE, div: 8'h00, rclk: 1'b0, si: 1'b0, edges: '0,
               gap: 16'h0000, flushed: 1'b0, done: 1'b0, cap: 1'b0,
               cap_data: PIX_RST};
    end else begin
      c_q <= c_d;
    end
  end

  sample_fifo #(.WIDTH(PIX_W), .DEPTH(DEPTH)) u_fifo (
    .CLK       (CLK),
    .SYS_RST   (SYS_RST),
    .IN_VALID  (c_q.cap),
    .IN_READY  (fifo_in_ready),
    .IN_DATA   (c_q.cap_data),
    .OUT_VALID (PIX_VALID),
    .OUT_READY (PIX_READY),
    .OUT_DATA  (PIX_DATA)
  );

  assign LINK.read_clk    = c_q.rclk;
  assign LINK.start_pulse = c_q.si;
  assign FRAME_DONE       = c_q.done;
  assign FLUSHED          = c_q.flushed;
endmodule : ctl_end
`default_nettype wire

// ==== link_checker.sv ====
// Purpose: Pin-level checks on the link between array and controller
// Assumes: Readout clock and start are sampled on CLK
// Notes:   Answer taken as one or two CLK after a readout rise is seen
`default_nettype none
module link_checker
  import array_pkg::*;
#(
  parameter int unsigned PIXELS = PIXEL_COUNT
) (
  input wire logic             CLK,
  input wire logic             SYS_RST,
  input wire logic             read_clk,
  input wire logic             start_pulse,
  input wire logic [PIX_W-1:0] pixel_out,
  input wire logic             pixel_oe,
  input wire logic             end_of_sequence_out
);
  logic        rclk_q;
  logic        sp_q;
  logic        go_q;
  logic [15:0] rises_q;
  logic [31:0] since_q;
  logic        rise;
  assign rise = read_clk & ~rclk_q;
  // Rises counted from the start rise, which counts as one
  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rclk_q  <= 1'b0;
      sp_q    <= 1'b0;
      go_q    <= 1'b0;
      rises_q <= 16'h0000;
      since_q <= 32'h0000_0000;
    end else begin
      rclk_q <= read_clk;
      if (rise && start_pulse) begin
        since_q <= 32'h0000_0000;
      end else if (since_q != 32'hFFFF_FFFF) begin
        since_q <= since_q + 32'h0000_0001;
      end
      if (rise) begin
        sp_q    <= start_pulse;
        go_q    <= go_q | start_pulse;
        rises_q <= start_pulse ? 16'h0001 : rises_q + 16'h0001;
      end
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  start_oe_a: assert property (rise && start_pulse |-> ##[1:2] pixel_oe)
    else $error("output not driven after start");
  last_flag_a: assert property ($rose(end_of_sequence_out) |-> rises_q == 16'(PIXELS) && pixel_oe)
    else $error("end flag not with last pixel");
  float_after_a: assert property ($fell(pixel_oe) |-> rises_q == 16'(PIXELS + 1))
    else $error("output floated at wrong rise");
  pixel_stands_a: assert property (pixel_oe && $changed(pixel_out) |-> $past(rise) || $past(rise, 2))
    else $error("pixel changed within a period");
  oe_moves_a: assert property ($changed(pixel_oe) |-> $past(rise) || $past(rise, 2))
    else $error("output enable moved without a rise");
  single_start_a: assert property (rise && start_pulse |-> !sp_q)
    else $error("start held over two rises");
  min_int_a: assert property (rise && start_pulse && go_q |-> rises_q >= 16'(PIXELS))
    else $error("starts closer than one frame");
  max_int_a: assert property (rise && start_pulse && go_q |-> since_q <= MAX_INT_CYC)
    else $error("starts further apart than the longest integration");
  clk_high_a: assert property ($rose(read_clk) |-> read_clk [*5])
    else $error("readout clock high too short");
  clk_low_a: assert property ($fell(read_clk) |-> !read_clk [*5])
    else $error("readout clock low too short");
  frame_c: cover property (rise && start_pulse);
  last_c: cover property ($rose(end_of_sequence_out));
  float_c: cover property ($fell(pixel_oe));
endmodule : link_checker
`default_nettype wire

// ==== tb.sv ====
// Purpose: Both ends joined; model of pixel values and counts vs design
// Assumes: Eight-pixel frames; light fixed within a phase
// Notes:   Flush frame after each reset clears integration, so frames are predictable
`default_nettype none
module tb;
  import array_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned NPIX = 8;
  logic             clk = 1'b0;
  logic             sys_rst = 1'b1;
  logic             run = 1'b0;
  logic             pix_ready = 1'b0;
  logic [PIX_W-1:0] light = 8'h00;
  logic             pix_valid, frame_done, flushed, irs, shs, eos_q;
  logic [PIX_W-1:0] pix_data, exp_pix;
  logic [IDX_W-1:0] access_index;
  logic [31:0]      rnd = 32'hb72f_bb24;
  logic [1:0]       thresh = 2'h3;
  int               bad_count = 0, checks_done = 0, got = 0, dones = 0;
  array_link_if array_link_if_inst ();
  always #10 clk = ~clk;
  array_end #(.PIXELS(NPIX)) array_end_inst (.CLK(clk), .SYS_RST(sys_rst),
    .LINK(array_link_if_inst), .LIGHT_LEVEL(light), .ACCESS_INDEX(access_index),
    .INTEGRATOR_RESET_SWITCH(irs), .SAMPLE_HOLD_SWITCH(shs));
  ctl_end #(.PIXELS(NPIX)) ctl_end_inst (.CLK(clk), .SYS_RST(sys_rst),
    .LINK(array_link_if_inst), .RUN(run), .PIX_VALID(pix_valid), .PIX_READY(pix_ready),
    .PIX_DATA(pix_data), .FRAME_DONE(frame_done), .FLUSHED(flushed));
  link_checker #(.PIXELS(NPIX)) link_checker_inst (.CLK(clk), .SYS_RST(sys_rst),
    .read_clk(array_link_if_inst.read_clk), .start_pulse(array_link_if_inst.start_pulse),
    .pixel_out(array_link_if_inst.pixel_out), .pixel_oe(array_link_if_inst.pixel_oe),
    .end_of_sequence_out(array_link_if_inst.end_of_sequence_out));
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] seen);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  // Low threshold slows the drain to one cycle in four, still faster than one pixel per readout period
  always @(posedge clk) begin
    #1;
    rnd = xorshift(rnd);
    pix_ready = (rnd[1:0] <= thresh);
  end
  always @(posedge clk) begin
    eos_q <= array_link_if_inst.end_of_sequence_out;
    if (frame_done === 1'b1) dones++;
    if (array_link_if_inst.end_of_sequence_out === 1'b1 && eos_q !== 1'b1)
      check("index at last pixel", 16'(NPIX - 1), 16'(access_index));
    if (pix_valid === 1'b1 && pix_ready === 1'b1) begin
      check("pixel value", 16'(exp_pix), 16'(pix_data));
      got++;
    end
  end
  // Saturating sum: dark gives zero, full light saturates after one edge
  task automatic phase(input logic [PIX_W-1:0] lvl, input logic [1:0] thr, input int frames);
    int idle;
    light = lvl;
    exp_pix = lvl;
    thresh = thr;
    got = 0;
    dones = 0;
    run = 1'b1;
    for (idle = 0; idle < 20000 && dones < frames; idle++) @(posedge clk);
    #1;
    run = 1'b0;
    idle = 0;
    while (idle < 200) begin
      @(posedge clk);
      idle = (pix_valid === 1'b1) ? 0 : idle + 1;
    end
    #1;
    check("flush done", 16'h0001, 16'(flushed));
    check("pixel count", 16'(dones * NPIX), 16'(got));
    check("frames seen", 16'h0001, 16'(dones >= frames));
  endtask : phase
  initial begin
    repeat (5) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    phase(8'h00, 2'h3, 3);
    sys_rst = 1'b1;
    @(posedge clk);
    #1;
    check("enable in reset", 16'h0000, 16'(array_link_if_inst.pixel_oe));
    check("flush flag in reset", 16'h0000, 16'(flushed));
    sys_rst = 1'b0;
    phase(8'hFF, 2'h0, 3);
    final_report();
  end
  initial begin
    #1_000_000;
    bad_count++;
    final_report();
  end
endmodule : tb
`default_nettype wire
